// *** rtl/fsm_pkg.sv ***
// package: memory map, sizes and timing constants for the flash/sram map decoder
package fsm_pkg;
   // flash geometry
   localparam int unsigned FLASH_KB = 32;
   localparam int unsigned SECTOR_BYTES = 1024;
   localparam int unsigned FLASH_SECTORS = FLASH_KB * 1024 / SECTOR_BYTES;
   localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
   localparam logic [31:0] FLASH_SIZE = 32'h0000_8000;
   localparam logic [31:0] FLASH_ALLOC_END = 32'h0FFF_FFFF;
   // sram geometry
   localparam logic [31:0] SRAM_SIZE = 32'h0000_1000;
   localparam logic [31:0] SRAM_BOUNDARY = 32'h2000_0000;
   localparam logic [31:0] SRAM_L_BASE = SRAM_BOUNDARY - (SRAM_SIZE >> 2);
   localparam logic [31:0] SRAM_U_END = SRAM_BOUNDARY + ((SRAM_SIZE >> 2) * 32'h3) - 32'h1;
   // debug erase register bit positions
   localparam int unsigned ERASE_REQ_BIT = 0;
   localparam int unsigned ERASE_BUSY_BIT = 0;
   // erase timing: one sector per step
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned SECTOR_ERASE_US = 2;
   localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
   localparam logic [7:0] ERASE_CNT_RST = 8'h00;
   localparam logic [5:0] SECTOR_RST = 6'h00;
   // power modes
   typedef enum logic [2:0] {
      FSM_PM_RUN = 3'h0,
      FSM_PM_STOP = 3'h1,
      FSM_PM_LEVEL3 = 3'h3,
      FSM_PM_LEVEL1 = 3'h5,
      FSM_PM_LEVEL0 = 3'h6
   } fsm_pwr_t;
   // region codes
   typedef enum logic [2:0] {
      FSM_RG_NONE = 3'h0,
      FSM_RG_FLASH = 3'h1,
      FSM_RG_FLASH_ERR = 3'h3,
      FSM_RG_SRAM_L = 3'h2,
      FSM_RG_SRAM_U = 3'h6
   } fsm_region_t;
   // erase sequencer states, gray along the path
   typedef enum logic [1:0] {
      FSM_ST_IDLE = 2'b00,
      FSM_ST_ACCEPT = 2'b01,
      FSM_ST_ERASE = 2'b11,
      FSM_ST_DONE = 2'b10
   } fsm_state_t;
endpackage

// *** rtl/fsm_sync.sv ***
// three-stage synchroniser with agreement filter for one async level
`timescale 1ns/1ps
module fsm_sync
   import fsm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level
   input wire logic din,
   output logic dout
);
   logic s1_ff, s2_ff, s3_ff, q_ff;
   logic nxt_q;

   always_comb begin
      nxt_q = q_ff;
      if (s2_ff == s3_ff) begin
         nxt_q = s3_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         q_ff <= 1'b0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end

   assign dout = q_ff;
endmodule

// *** rtl/fsm_map_decode.sv ***
// flash and sram address decoder with debugger mass-erase sequencer
// ----------------------------------------------------------------
// Notes on behaviour
// [R01] one 32 KB flash block in 1 KB sectors
// [R02] flash is contiguous from address zero, no gaps
// [R03] allocated flash range beyond implemented size answers with bus error
// [R04] only normal flash mode; test mode unreachable
// [R05] debugger sets erase control bit 0 to erase the whole flash
// [R06] erase status bit 0 set once the erase request is accepted
// [R07] erase status bit cleared when the whole erase has finished
// [R08] sram split into lower quarter and upper three quarters
// [R09] lower range ends just below boundary, starts boundary minus quarter
// [R10] upper range starts at boundary, spans three quarters, contiguous
// [R11] sram retained down to level3 stop; lost in level1 and level0
// [R12] sram reachable by every crossbar master
// [R13] lower 0x1FFFFC00-0x1FFFFFFF, upper 0x20000000-0x20000BFF
// ----------------------------------------------------------------
`timescale 1ns/1ps
module fsm_map_decode
   import fsm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // crossbar request, any master
   input wire logic bus_valid,
   input wire logic [31:0] bus_addr,
   input wire logic [3:0] bus_master,
   output logic bus_ready,
   output logic bus_error,
   output logic flash_sel,
   output logic sram_sel,
   output logic sram_upper,
   output logic [14:0] flash_offset,
   output logic [11:0] sram_offset,
   output logic [3:0] resp_master,
   // debug erase control from serial_wire_debug_port
   input wire logic debug_erase_control,
   output logic debug_erase_status,
   // flash array erase
   output logic flash_erase_en,
   output logic [5:0] flash_erase_sector,
   output logic nonvolatile_test_mode,
   // power mode
   input wire logic [2:0] power_mode,
   output logic sram_retain,
   output logic sram_lost
);
   // ----------------------------------------------------------------
   // decode function
   // ----------------------------------------------------------------
   function automatic fsm_region_t decode(input logic [31:0] a);
      fsm_region_t r;
      r = FSM_RG_NONE;
      if (a < FLASH_SIZE) begin
         r = FSM_RG_FLASH; // see [R01] see [R02]
      end else if (a <= FLASH_ALLOC_END) begin
         r = FSM_RG_FLASH_ERR; // see [R03]
      end else if (a >= SRAM_L_BASE && a < SRAM_BOUNDARY) begin
         r = FSM_RG_SRAM_L; // see [R08] see [R09] see [R13]
      end else if (a >= SRAM_BOUNDARY && a <= SRAM_U_END) begin
         r = FSM_RG_SRAM_U; // see [R10] see [R13]
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // bus response
   // ----------------------------------------------------------------
   fsm_region_t reg_q;
   logic rdy_ff, err_ff, fsel_ff, ssel_ff, sup_ff;
   logic [14:0] foff_ff;
   logic [11:0] soff_ff;
   logic [3:0] mst_ff;
   logic nxt_rdy, nxt_err, nxt_fsel, nxt_ssel, nxt_sup;
   logic [14:0] nxt_foff;
   logic [11:0] nxt_soff;
   logic [3:0] nxt_mst;
   logic busy_ff;

   always_comb begin
      reg_q = decode(bus_addr);
      nxt_rdy = bus_valid;
      nxt_mst = bus_valid ? bus_master : mst_ff; // see [R12]
      nxt_err = 1'b0;
      nxt_fsel = 1'b0;
      nxt_ssel = 1'b0;
      nxt_sup = 1'b0;
      nxt_foff = foff_ff;
      nxt_soff = soff_ff;
      if (bus_valid) begin
         unique case (reg_q)
            FSM_RG_FLASH: begin
               // flash reads answer with bus error while mass erase runs
               nxt_fsel = !busy_ff;
               nxt_err = busy_ff;
               nxt_foff = bus_addr[14:0];
            end
            FSM_RG_SRAM_L, FSM_RG_SRAM_U: begin
               nxt_ssel = 1'b1; // see [R12]
               nxt_sup = (reg_q == FSM_RG_SRAM_U);
               nxt_soff = 12'(bus_addr - SRAM_L_BASE);
            end
            FSM_RG_FLASH_ERR: begin
               nxt_err = 1'b1; // see [R03]
            end
            FSM_RG_NONE: begin
               nxt_err = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_ff <= 1'b0;
         err_ff <= 1'b0;
         fsel_ff <= 1'b0;
         ssel_ff <= 1'b0;
         sup_ff <= 1'b0;
         foff_ff <= 15'h0000;
         soff_ff <= 12'h000;
         mst_ff <= 4'h0;
      end else begin
         rdy_ff <= nxt_rdy;
         err_ff <= nxt_err;
         fsel_ff <= nxt_fsel;
         ssel_ff <= nxt_ssel;
         sup_ff <= nxt_sup;
         foff_ff <= nxt_foff;
         soff_ff <= nxt_soff;
         mst_ff <= nxt_mst;
      end
   end

   assign bus_ready = rdy_ff;
   assign bus_error = err_ff;
   assign flash_sel = fsel_ff;
   assign sram_sel = ssel_ff;
   assign sram_upper = sup_ff;
   assign flash_offset = foff_ff;
   assign sram_offset = soff_ff;
   assign resp_master = mst_ff;
   // normal mode only; the test mode line is never raised
   assign nonvolatile_test_mode = 1'b0; // see [R04]

   // ----------------------------------------------------------------
   // mass erase sequencer
   // ----------------------------------------------------------------
   logic req_sync;
   logic req_d_ff;
   fsm_state_t st_ff, nxt_st;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [5:0] sec_ff, nxt_sec;
   logic nxt_req_d;

   // debugger port sits in its own clock domain
   fsm_sync u_req_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(debug_erase_control),
      .dout(req_sync)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sec = sec_ff;
      nxt_req_d = req_sync;
      unique case (st_ff)
         FSM_ST_IDLE: begin
            if (req_sync && !req_d_ff) begin
               nxt_st = FSM_ST_ACCEPT; // see [R05]
            end
         end
         FSM_ST_ACCEPT: begin
            nxt_st = FSM_ST_ERASE; // see [R06]
            nxt_cnt = ERASE_CNT_RST;
            nxt_sec = SECTOR_RST;
         end
         FSM_ST_ERASE: begin
            if (cnt_ff == 8'(SECTOR_ERASE_CYC - 1)) begin
               nxt_cnt = ERASE_CNT_RST;
               if (sec_ff == 6'(FLASH_SECTORS - 1)) begin
                  nxt_st = FSM_ST_DONE; // see [R05]
               end else begin
                  nxt_sec = sec_ff + 6'h01;
               end
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         FSM_ST_DONE: begin
            nxt_st = FSM_ST_IDLE; // see [R07]
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= FSM_ST_IDLE;
         cnt_ff <= ERASE_CNT_RST;
         sec_ff <= SECTOR_RST;
         req_d_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sec_ff <= nxt_sec;
         req_d_ff <= nxt_req_d;
      end
   end

   always_comb begin
      busy_ff = (st_ff == FSM_ST_ACCEPT) || (st_ff == FSM_ST_ERASE);
   end

   assign debug_erase_status = busy_ff; // see [R06] see [R07]
   assign flash_erase_en = (st_ff == FSM_ST_ERASE);
   assign flash_erase_sector = sec_ff;

   // ----------------------------------------------------------------
   // retention
   // ----------------------------------------------------------------
   always_comb begin
      sram_retain = 1'b1;
      sram_lost = 1'b0;
      if (power_mode == FSM_PM_LEVEL1 || power_mode == FSM_PM_LEVEL0) begin
         sram_retain = 1'b0; // see [R11]
         sram_lost = 1'b1;
      end
   end
endmodule

// *** verification/fsm_map_decode_assertions.sv ***
// checker: port-level properties of the flash/sram map decoder
`timescale 1ns/1ps
module fsm_map_decode_assertions
   import fsm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus side
   input wire logic bus_valid,
   input wire logic [31:0] bus_addr,
   input wire logic [3:0] bus_master,
   input wire logic bus_ready,
   input wire logic bus_error,
   input wire logic flash_sel,
   input wire logic sram_sel,
   input wire logic sram_upper,
   input wire logic [14:0] flash_offset,
   input wire logic [11:0] sram_offset,
   input wire logic [3:0] resp_master,
   // erase and power
   input wire logic debug_erase_status,
   input wire logic flash_erase_en,
   input wire logic [5:0] flash_erase_sector,
   input wire logic nonvolatile_test_mode,
   input wire logic [2:0] power_mode,
   input wire logic sram_retain,
   input wire logic sram_lost
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   reply_echo_a: assert property (bus_valid
      |=> bus_ready && resp_master == $past(bus_master))
      else $error("bus reply missing or wrong master");
   idle_quiet_a: assert property (!bus_valid |=> !bus_ready)
      else $error("reply without request");
   flash_hit_a: assert property (bus_valid && bus_addr < FLASH_SIZE
      && !debug_erase_status
      |=> flash_sel && !bus_error && flash_offset == $past(bus_addr[14:0]))
      else $error("flash decode wrong");
   flash_gap_a: assert property (bus_valid && bus_addr >= FLASH_SIZE
      && bus_addr <= FLASH_ALLOC_END |=> bus_error && !flash_sel)
      else $error("missing flash gap error");
   sram_low_a: assert property (bus_valid && bus_addr >= SRAM_L_BASE
      && bus_addr < SRAM_BOUNDARY
      |=> sram_sel && !sram_upper && sram_offset == 12'($past(bus_addr) - SRAM_L_BASE))
      else $error("lower sram decode wrong");
   sram_up_a: assert property (bus_valid && bus_addr >= SRAM_BOUNDARY
      && bus_addr <= SRAM_U_END |=> sram_sel && sram_upper && !bus_error
      && sram_offset == 12'($past(bus_addr) - SRAM_L_BASE))
      else $error("upper sram decode wrong");
   unmapped_quiet_a: assert property (bus_valid && bus_addr > SRAM_U_END
      |=> !sram_sel && !flash_sel && !bus_error)
      else $error("select past sram end");
   test_off_a: assert property (!nonvolatile_test_mode)
      else $error("test mode reachable");
   retain_mode_a: assert property (sram_retain != sram_lost
      && sram_lost == (power_mode inside {FSM_PM_LEVEL1, FSM_PM_LEVEL0}))
      else $error("retention wrong for power mode");
   erase_start_a: assert property ($rose(debug_erase_status)
      |=> flash_erase_en && flash_erase_sector == 6'h00)
      else $error("erase did not start at sector zero");
   erase_flag_a: assert property (flash_erase_en |-> debug_erase_status)
      else $error("erasing without status");
   erase_end_a: assert property ($fell(debug_erase_status)
      |-> $past(flash_erase_sector) == 6'(FLASH_SECTORS - 1))
      else $error("status cleared before last sector");
   cover property (bus_valid ##1 bus_error);
   cover property (bus_valid && bus_addr > SRAM_U_END);
   cover property ($fell(debug_erase_status));
endmodule

bind fsm_map_decode fsm_map_decode_assertions u_fsm_map_decode_assertions (.clk, .rst_n,
   .bus_valid, .bus_addr, .bus_master, .bus_ready, .bus_error, .flash_sel, .sram_sel,
   .sram_upper, .flash_offset, .sram_offset, .resp_master, .debug_erase_status,
   .flash_erase_en, .flash_erase_sector, .nonvolatile_test_mode, .power_mode,
   .sram_retain, .sram_lost);

// *** verification/fsm_dbg_model.sv ***
// partner: debugger requesting a whole-array erase
`timescale 1ns/1ps
module fsm_dbg_model (
   // clock
   input wire logic clk,
   // command from bench
   input wire logic go,
   // debug port
   input wire logic debug_erase_status,
   output logic debug_erase_control
);
   initial debug_erase_control = 1'b0;
   // held until accepted; dropped so a later rise is a fresh request
   always @(posedge clk) begin
      if (go) debug_erase_control <= 1'b1;
      else if (debug_erase_status) debug_erase_control <= 1'b0;
   end
endmodule

// *** verification/fsm_map_decode_tb.sv ***
// bench: map decode, retention and erase sequence of the map decoder
`timescale 1ns/1ps
module fsm_map_decode_tb
   import fsm_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, bus_valid = 1'b0, erase_go = 1'b0;
   logic [31:0] bus_addr = 32'h0;
   logic [3:0] bus_master = 4'h0;
   logic [2:0] power_mode = 3'h0;
   logic bus_ready, bus_error, flash_sel, sram_sel, sram_upper, debug_erase_control;
   logic debug_erase_status, flash_erase_en, nonvolatile_test_mode, sram_retain, sram_lost;
   logic [14:0] flash_offset;
   logic [11:0] sram_offset;
   logic [3:0] resp_master;
   logic [5:0] flash_erase_sector;
   int n_mismatch = 0, comparisons = 0, cyc = 0, en_cyc = 0;
   always #12.5 clk = ~clk;
   fsm_map_decode u_fsm_map_decode (.clk, .rst_n, .bus_valid, .bus_addr, .bus_master,
      .bus_ready, .bus_error, .flash_sel, .sram_sel, .sram_upper, .flash_offset, .sram_offset,
      .resp_master, .debug_erase_control, .debug_erase_status, .flash_erase_en,
      .flash_erase_sector, .nonvolatile_test_mode, .power_mode, .sram_retain, .sram_lost);
   fsm_dbg_model u_fsm_dbg_model (.clk, .go(erase_go), .debug_erase_status,
      .debug_erase_control);
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", what, exp, got);
      end
   endtask
   // {error, flash, sram, upper}
   function automatic logic [3:0] exp_of(input logic [31:0] a);
      if (a < FLASH_SIZE) return 4'h4;
      if (a <= FLASH_ALLOC_END) return 4'h8;
      if (a >= SRAM_L_BASE && a < SRAM_BOUNDARY) return 4'h2;
      if (a >= SRAM_BOUNDARY && a <= SRAM_U_END) return 4'h3;
      return 4'h0;
   endfunction
   // ------------------------------
   // scenarios
   // ------------------------------
   // back to back across every region edge
   task automatic t_map();
      logic [31:0] tab [10] = '{32'h0, 32'h7FFF, 32'h8000, 32'h0FFF_FFFF, 32'h1FFF_FBFF,
         32'h1FFF_FC00, 32'h1FFF_FFFF, 32'h2000_0000, 32'h2000_0BFF, 32'h2000_0C00};
      logic [3:0] e;
      logic [3:0] got;
      logic [31:0] a;
      logic [11:0] so;
      for (int i = 0; i <= 10; i++) begin
         @(posedge clk);
         bus_valid <= (i < 10);
         bus_addr <= tab[i % 10];
         bus_master <= 4'(i);
         #1;
         if (i > 0) begin
            a = tab[i-1];
            e = exp_of(a);
            so = 12'(a - SRAM_L_BASE);
            got = {bus_error, flash_sel, sram_sel, sram_upper};
            chk("ready", 32'h1, 32'(bus_ready));
            chk("region", 32'(e), 32'(got));
            chk("master", 32'(i - 1), 32'(resp_master));
            if (e[2]) chk("flash offset", 32'(a[14:0]), 32'(flash_offset));
            if (e[1]) chk("sram offset", 32'(so), 32'(sram_offset));
         end
      end
   endtask
   task automatic t_power();
      logic [2:0] pm [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         power_mode <= pm[i];
         @(posedge clk);
         #1;
         chk("retain", 32'(i < 3), {31'h0, sram_retain});
         chk("lost", 32'(i >= 3), {31'h0, sram_lost});
      end
      chk("test mode", 32'h0, {31'h0, nonvolatile_test_mode});
   endtask
   // counted away from the edge that moves the sequencer, so no race
   always @(negedge clk) begin
      if (flash_erase_en === 1'b1) en_cyc++;
   end
   task automatic t_erase();
      int n = 0;
      int base = en_cyc;
      @(posedge clk);
      erase_go <= 1'b1;
      @(posedge clk);
      erase_go <= 1'b0;
      while (debug_erase_status !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("accepted", 32'h1, {31'h0, debug_erase_status});
      // flash reads are refused while the array is being wiped
      @(posedge clk);
      bus_valid <= 1'b1;
      bus_addr <= 32'h0000_0100;
      @(posedge clk);
      bus_valid <= 1'b0;
      #1;
      chk("busy flash error", 32'h1, 32'(bus_error));
      chk("busy flash sel", 32'h0, 32'(flash_sel));
      n = 0;
      while (debug_erase_status !== 1'b0 && n < 4000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("finished", 32'h0, {31'h0, debug_erase_status});
      chk("erase span", FLASH_SECTORS * SECTOR_ERASE_CYC, 32'(en_cyc - base));
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_map();
      t_power();
      t_erase();
      t_map();
      summarize();
   end
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
endmodule
